//--- hw/tcid_pkg.sv
// Constants for the trace capability identification registers
`default_nettype none
package tcid_pkg;
	localparam int REG_W = 64;
	// System register encodings (op0, op1, CRn, CRm, op2)
	localparam logic [1:0] OP0_TRACE = 2'h2;
	localparam logic [2:0] OP1_TRACE = 3'h1;
	localparam logic [3:0] CRN_ID = 4'h0;
	localparam logic [3:0] CRM_RSV13 = 4'h5;
	localparam logic [2:0] OP2_RSV13 = 3'h6;
	localparam logic [3:0] CRM_CAP0 = 4'h8;
	localparam logic [2:0] OP2_CAP0 = 3'h7;
	// Privilege levels and trap class
	localparam logic [1:0] LVL_USER = 2'h0;
	localparam logic [1:0] LVL_KERN = 2'h1;
	localparam logic [1:0] LVL_HYP = 2'h2;
	localparam logic [1:0] LVL_MON = 2'h3;
	localparam logic [5:0] TRAP_CLASS = 6'h18;
	// Reserved register value; field values of the main capability register
	localparam logic [0:0] TXN_START_KIND = 1'h0;
	localparam logic [0:0] COMMIT_MODE = 1'h1;
	localparam logic [4:0] TS_WIDTH_CODE = 5'h08;
	localparam logic [1:0] Q_SUPPORT = 2'h0;
	localparam logic [0:0] Q_FILTER = 1'h0;
	localparam logic [1:0] EVENT_COUNT = 2'h3;
	localparam logic [0:0] RET_STACK = 1'h1;
	localparam logic [0:0] CYC_COUNT = 1'h1;
	localparam logic [0:0] COND_TRACE = 1'h0;
	localparam logic [0:0] BR_BCAST = 1'h1;
	localparam logic [1:0] DATA_TRACE = 2'h0;
	localparam logic [1:0] LS_RETIRE = 2'h0;
	localparam logic [0:0] RES_ONE = 1'h1;
	localparam logic [63:0] RSV13_VALUE = 64'h0;
	localparam logic [63:0] CAP0_VALUE = {33'h0, TXN_START_KIND, COMMIT_MODE,
		TS_WIDTH_CODE, 7'h00, Q_SUPPORT, Q_FILTER, 2'h0, EVENT_COUNT, RET_STACK,
		1'h0, CYC_COUNT, COND_TRACE, BR_BCAST, DATA_TRACE, LS_RETIRE, RES_ONE};
	// Field positions of the main capability register
	localparam int TOP_RSV_LO = 31;
	localparam int TXN_START_POS = 30;
	localparam int COMMIT_MODE_POS = 29;
	localparam int TS_WIDTH_HI = 28;
	localparam int TS_WIDTH_LO = 24;
	localparam int MID_RSV_HI = 23;
	localparam int MID_RSV_LO = 17;
	localparam int Q_SUPPORT_HI = 16;
	localparam int Q_SUPPORT_LO = 15;
	localparam int Q_FILTER_POS = 14;
	localparam int LOW_RSV_HI = 13;
	localparam int LOW_RSV_LO = 12;
	localparam int EVENT_COUNT_HI = 11;
	localparam int EVENT_COUNT_LO = 10;
	localparam int RET_STACK_POS = 9;
	localparam int GAP_RSV_POS = 8;
	localparam int CYC_COUNT_POS = 7;
	localparam int COND_TRACE_POS = 6;
	localparam int BR_BCAST_POS = 5;
	localparam int DATA_TRACE_HI = 4;
	localparam int DATA_TRACE_LO = 3;
	localparam int LS_RETIRE_HI = 2;
	localparam int LS_RETIRE_LO = 1;
	localparam int RES_ONE_POS = 0;
endpackage
`default_nettype wire

//--- hw/tcid_regs.sv
// Trace capability ID registers with privilege checked reads
//Contract
//- Least privileged level reads are undefined
//- Level one trap bit traps to level one
//- Hypervisor trace trap bit traps to hypervisor
//- Fine grained ID trap traps to hypervisor
//- Monitor level traps on monitor bit
//- Hypervisor level: own bit, then monitor
//- Reserved register reads all zeros
//- Both registers 64 bits, always present
//- Reserved fields zero, bit zero one
//- Bit 30 reads zero
//- Bit 29 reads one
//- Timestamp code reads 64-bit global
//- No Q support or filtering
//- Event count field reads all ones
//- Return stack bit reads one
//- Cycle counting bit reads one
//- Branch broadcast bit reads one
//- Conditional, data, load/store fields zero
`default_nettype none
module tcid_regs (
	input wire logic mclk,
	input wire logic rst,
	input wire logic rd_req,
	input wire logic [1:0] rd_op0,
	input wire logic [2:0] rd_op1,
	input wire logic [3:0] rd_crn,
	input wire logic [3:0] rd_crm,
	input wire logic [2:0] rd_op2,
	input wire logic [1:0] current_privilege_level,
	input wire logic hyp_level_enabled,
	input wire logic lvl1_trace_trap_bit,
	input wire logic hyp_trace_trap_bit,
	input wire logic monitor_trace_trap_bit,
	input wire logic fine_grain_trap_enable,
	input wire logic hyp_id_read_fine_trap,
	output logic rd_done,
	output logic rd_hit,
	output logic [63:0] rd_data,
	output logic rd_undef,
	output logic rd_trap,
	output logic [1:0] trap_level,
	output logic [5:0] trap_class
);
	wire logic sel_rsv = rd_op0 == tcid_pkg::OP0_TRACE && rd_op1 == tcid_pkg::OP1_TRACE
		&& rd_crn == tcid_pkg::CRN_ID && rd_crm == tcid_pkg::CRM_RSV13
		&& rd_op2 == tcid_pkg::OP2_RSV13;
	wire logic sel_cap = rd_op0 == tcid_pkg::OP0_TRACE && rd_op1 == tcid_pkg::OP1_TRACE
		&& rd_crn == tcid_pkg::CRN_ID && rd_crm == tcid_pkg::CRM_CAP0
		&& rd_op2 == tcid_pkg::OP2_CAP0;
	wire logic hit = rd_req && (sel_rsv || sel_cap);
	wire logic is_user = current_privilege_level == tcid_pkg::LVL_USER;
	wire logic is_kern = current_privilege_level == tcid_pkg::LVL_KERN;
	wire logic is_hyp = current_privilege_level == tcid_pkg::LVL_HYP;
	wire logic is_mon = current_privilege_level == tcid_pkg::LVL_MON;
	wire logic k_t1 = is_kern && lvl1_trace_trap_bit;
	wire logic k_t2a = is_kern && !k_t1 && hyp_level_enabled && hyp_trace_trap_bit;
	wire logic k_t2b = is_kern && !k_t1 && !k_t2a && hyp_level_enabled
		&& fine_grain_trap_enable && hyp_id_read_fine_trap;
	wire logic k_t3 = is_kern && !k_t1 && !k_t2a && !k_t2b && monitor_trace_trap_bit;
	wire logic h_t2 = is_hyp && hyp_trace_trap_bit;
	wire logic h_t3 = is_hyp && !hyp_trace_trap_bit && monitor_trace_trap_bit;
	wire logic m_t3 = is_mon && monitor_trace_trap_bit;
	wire logic to_l1 = k_t1;
	wire logic to_l2 = k_t2a || k_t2b || h_t2;
	wire logic to_l3 = k_t3 || h_t3 || m_t3;
	wire logic any_trap = to_l1 || to_l2 || to_l3;
	wire logic [1:0] lvl_d = to_l1 ? tcid_pkg::LVL_KERN
		: to_l2 ? tcid_pkg::LVL_HYP : tcid_pkg::LVL_MON;
	wire logic [63:0] val_sel = sel_cap ? tcid_pkg::CAP0_VALUE : tcid_pkg::RSV13_VALUE;
	wire logic undef_d = hit && is_user;
	wire logic ok_d = hit && !is_user && !any_trap;
	// Successful reads of each register
	wire logic cap_ok = ok_d && sel_cap;
	wire logic rsv_ok = ok_d && sel_rsv;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_done <= 1'b0;
			rd_hit <= 1'b0;
			rd_data <= 64'h0;
			rd_undef <= 1'b0;
			rd_trap <= 1'b0;
			trap_level <= 2'h0;
			trap_class <= 6'h00;
		end else begin
			rd_done <= rd_req;
			rd_hit <= hit;
			rd_data <= ok_d ? val_sel : 64'h0;
			rd_undef <= undef_d;
			rd_trap <= hit && !is_user && any_trap;
			trap_level <= (hit && !is_user && any_trap) ? lvl_d : 2'h0;
			trap_class <= (hit && !is_user && any_trap) ? tcid_pkg::TRAP_CLASS : 6'h00;
		end
	end

	// Assertions
	// user read undefined
	user_undef_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_user |=> rd_undef && !rd_trap && rd_data == '0)
		else $error("user read not undefined");

	user_class_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_user |=> trap_level == '0 && trap_class == '0)
		else $error("user read reports a trap");

	undef_excl_a: assert property (@(posedge mclk) disable iff (rst)
		rd_undef |-> !rd_trap && rd_hit && rd_data == '0)
		else $error("undefined read carries data");

	kern_l1_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && lvl1_trace_trap_bit |=> rd_trap && trap_level == tcid_pkg::LVL_KERN
		&& trap_class == tcid_pkg::TRAP_CLASS)
		else $error("level one trap missing");

	kern_l1_first_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && lvl1_trace_trap_bit && hyp_level_enabled && hyp_trace_trap_bit
		|=> trap_level == tcid_pkg::LVL_KERN)
		else $error("level one trap lost priority");

	trap_class_a: assert property (@(posedge mclk) disable iff (rst)
		rd_trap |-> trap_class == tcid_pkg::TRAP_CLASS)
		else $error("trap class wrong");

	no_trap_class_a: assert property (@(posedge mclk) disable iff (rst)
		!rd_trap |-> trap_class == '0 && trap_level == '0)
		else $error("trap fields set without trap");

	kern_hyp_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && !lvl1_trace_trap_bit && hyp_level_enabled && hyp_trace_trap_bit
		|=> rd_trap && trap_level == tcid_pkg::LVL_HYP)
		else $error("hypervisor trap missing");

	hyp_gate_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && !lvl1_trace_trap_bit && !hyp_level_enabled
		&& !monitor_trace_trap_bit |=> !rd_trap)
		else $error("trap taken with hypervisor off");

	fine_trap_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && !lvl1_trace_trap_bit && hyp_level_enabled
		&& fine_grain_trap_enable && hyp_id_read_fine_trap |=> rd_trap
		&& trap_level == tcid_pkg::LVL_HYP)
		else $error("fine grained trap missing");

	fine_gate_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && !lvl1_trace_trap_bit && hyp_level_enabled && !hyp_trace_trap_bit
		&& !fine_grain_trap_enable && !monitor_trace_trap_bit |=> !rd_trap)
		else $error("fine trap taken while disabled");

	kern_mon_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && !lvl1_trace_trap_bit && !(hyp_level_enabled && (hyp_trace_trap_bit
		|| fine_grain_trap_enable && hyp_id_read_fine_trap)) && monitor_trace_trap_bit
		|=> rd_trap && trap_level == tcid_pkg::LVL_MON)
		else $error("kernel monitor trap missing");

	kern_ok_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_kern && !lvl1_trace_trap_bit && !(hyp_level_enabled && (hyp_trace_trap_bit
		|| fine_grain_trap_enable && hyp_id_read_fine_trap)) && !monitor_trace_trap_bit
		|=> !rd_trap && !rd_undef && rd_hit)
		else $error("kernel read refused");

	mon_trap_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_mon |=> rd_trap == $past(monitor_trace_trap_bit)
		&& (rd_trap ? trap_level == tcid_pkg::LVL_MON : rd_data == $past(val_sel)))
		else $error("monitor level read wrong");

	mon_ok_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_mon && !monitor_trace_trap_bit |=> !rd_trap && !rd_undef)
		else $error("monitor read refused");

	hyp_own_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_hyp && hyp_trace_trap_bit |=> rd_trap && trap_level == tcid_pkg::LVL_HYP)
		else $error("hypervisor own trap missing");

	hyp_order_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_hyp && !hyp_trace_trap_bit && monitor_trace_trap_bit
		|=> rd_trap && trap_level == tcid_pkg::LVL_MON)
		else $error("hypervisor priority wrong");

	hyp_ok_a: assert property (@(posedge mclk) disable iff (rst)
		hit && is_hyp && !hyp_trace_trap_bit && !monitor_trace_trap_bit |=> !rd_trap && !rd_undef)
		else $error("hypervisor read refused");

	trap_data_a: assert property (@(posedge mclk) disable iff (rst)
		rd_trap |-> rd_data == '0 && rd_hit && !rd_undef)
		else $error("trapped read carries data");

	rsv_zero_a: assert property (@(posedge mclk) disable iff (rst)
		rd_done && !rd_trap && !rd_undef && $past(sel_rsv) |-> rd_data == '0)
		else $error("reserved register not zero");

	rsv_hit_a: assert property (@(posedge mclk) disable iff (rst)
		hit && sel_rsv |=> rd_hit && rd_done)
		else $error("reserved register not decoded");

	rsv_read_a: assert property (@(posedge mclk) disable iff (rst)
		rsv_ok |=> rd_data == '0 && !rd_trap && !rd_undef)
		else $error("reserved read wrong");

	both_present_a: assert property (@(posedge mclk) disable iff (rst)
		rd_req && (sel_rsv || sel_cap) |=> rd_hit)
		else $error("register missing");

	cap_value_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data == 64'h0000_0000_2800_0EA1)
		else $error("capability value wrong");

	top_rsv_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::REG_W-1:tcid_pkg::TOP_RSV_LO] == '0)
		else $error("upper reserved bits set");

	mid_rsv_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::MID_RSV_HI:tcid_pkg::MID_RSV_LO] == '0)
		else $error("middle reserved bits set");

	low_rsv_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::LOW_RSV_HI:tcid_pkg::LOW_RSV_LO] == '0)
		else $error("lower reserved bits set");

	gap_rsv_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::GAP_RSV_POS] == '0)
		else $error("single reserved bit set");

	one_bit_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::RES_ONE_POS] == tcid_pkg::RES_ONE)
		else $error("reserved one bit clear");

	txn_kind_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::TXN_START_POS] == tcid_pkg::TXN_START_KIND)
		else $error("transaction start kind wrong");

	commit_mode_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::COMMIT_MODE_POS] == tcid_pkg::COMMIT_MODE)
		else $error("commit mode wrong");

	ts_width_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::TS_WIDTH_HI:tcid_pkg::TS_WIDTH_LO] == tcid_pkg::TS_WIDTH_CODE)
		else $error("timestamp width code wrong");

	q_support_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::Q_SUPPORT_HI:tcid_pkg::Q_SUPPORT_LO] == tcid_pkg::Q_SUPPORT)
		else $error("Q support field wrong");

	q_filter_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::Q_FILTER_POS] == tcid_pkg::Q_FILTER)
		else $error("Q filter field wrong");

	event_count_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::EVENT_COUNT_HI:tcid_pkg::EVENT_COUNT_LO] == tcid_pkg::EVENT_COUNT)
		else $error("event count wrong");

	ret_stack_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::RET_STACK_POS] == tcid_pkg::RET_STACK)
		else $error("return stack bit wrong");

	cyc_count_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::CYC_COUNT_POS] == tcid_pkg::CYC_COUNT)
		else $error("cycle counting bit wrong");

	br_bcast_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::BR_BCAST_POS] == tcid_pkg::BR_BCAST)
		else $error("branch broadcast bit wrong");

	cond_trace_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::COND_TRACE_POS] == tcid_pkg::COND_TRACE)
		else $error("conditional trace bit wrong");

	data_trace_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::DATA_TRACE_HI:tcid_pkg::DATA_TRACE_LO] == tcid_pkg::DATA_TRACE)
		else $error("data trace field wrong");

	ls_retire_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok |=> rd_data[tcid_pkg::LS_RETIRE_HI:tcid_pkg::LS_RETIRE_LO] == tcid_pkg::LS_RETIRE)
		else $error("load store field wrong");

	done_next_a: assert property (@(posedge mclk) disable iff (rst)
		rd_req |=> rd_done)
		else $error("read not answered");

	idle_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		!rd_req |=> !rd_done && !rd_hit && rd_data == '0 && !rd_trap && !rd_undef
		&& trap_level == '0)
		else $error("outputs active while idle");

	cap_repeat_a: assert property (@(posedge mclk) disable iff (rst)
		cap_ok ##1 cap_ok |=> rd_data == $past(rd_data))
		else $error("capability value changed");

	miss_a: assert property (@(posedge mclk) disable iff (rst)
		rd_req && !sel_rsv && !sel_cap |=> rd_done && !rd_hit && rd_data == '0
		&& !rd_trap && !rd_undef)
		else $error("unmatched encoding answered");
endmodule
`default_nettype wire

//--- verif/tcid_regs_test.sv
// Self-checking bench for the trace capability ID registers
`default_nettype none
module tcid_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic rd_req = 1'b0;
	logic [1:0] rd_op0 = tcid_pkg::OP0_TRACE;
	logic [2:0] rd_op1 = tcid_pkg::OP1_TRACE;
	logic [3:0] rd_crn = tcid_pkg::CRN_ID;
	logic [3:0] rd_crm = 4'h0;
	logic [2:0] rd_op2 = 3'h0;
	logic [1:0] current_privilege_level = 2'h0;
	logic hyp_level_enabled = 1'b0;
	logic lvl1_trace_trap_bit = 1'b0;
	logic hyp_trace_trap_bit = 1'b0;
	logic monitor_trace_trap_bit = 1'b0;
	logic fine_grain_trap_enable = 1'b0;
	logic hyp_id_read_fine_trap = 1'b0;
	logic rd_done, rd_hit, rd_undef, rd_trap;
	logic [63:0] rd_data;
	logic [1:0] trap_level;
	logic [5:0] trap_class;
	logic [11:0] flags;
	logic [12:0] r;
	int checks = 0;
	int mismatches = 0;
	// Row: select, level, {hyp_en,l1,hyp,mon,fine_en,fine}, undef, trap, target level
	logic [12:0] rows [15] = '{13'h1C00, 13'h0C00, 13'h1008, 13'h1505, 13'h1686, 13'h1480,
		13'h1636, 13'h1610, 13'h1A30, 13'h1447, 13'h18C6, 13'h1847, 13'h1C47, 13'h0E80, 13'h1785};
	assign flags = {rd_done, rd_hit, rd_undef, rd_trap, trap_level, trap_class};
	tcid_regs DUT (
		.mclk(mclk),
		.rst(rst),
		.rd_req(rd_req),
		.rd_op0(rd_op0),
		.rd_op1(rd_op1),
		.rd_crn(rd_crn),
		.rd_crm(rd_crm),
		.rd_op2(rd_op2),
		.current_privilege_level(current_privilege_level),
		.hyp_level_enabled(hyp_level_enabled),
		.lvl1_trace_trap_bit(lvl1_trace_trap_bit),
		.hyp_trace_trap_bit(hyp_trace_trap_bit),
		.monitor_trace_trap_bit(monitor_trace_trap_bit),
		.fine_grain_trap_enable(fine_grain_trap_enable),
		.hyp_id_read_fine_trap(hyp_id_read_fine_trap),
		.rd_done(rd_done),
		.rd_hit(rd_hit),
		.rd_data(rd_data),
		.rd_undef(rd_undef),
		.rd_trap(rd_trap),
		.trap_level(trap_level),
		.trap_class(trap_class)
	);
	always #50 mclk = ~mclk;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Drives one read at the falling edge, leaves the strobe up
	task automatic req(input logic s, input logic [1:0] l, input logic [5:0] c);
		current_privilege_level = l;
		{hyp_level_enabled, lvl1_trace_trap_bit, hyp_trace_trap_bit} = c[5:3];
		{monitor_trace_trap_bit, fine_grain_trap_enable, hyp_id_read_fine_trap} = c[2:0];
		rd_crm = s ? tcid_pkg::CRM_CAP0 : tcid_pkg::CRM_RSV13;
		rd_op2 = s ? tcid_pkg::OP2_CAP0 : tcid_pkg::OP2_RSV13;
		rd_req = 1'b1;
		@(negedge mclk);
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		check(64'(flags), 64'h0);
		check(rd_data, 64'h0);
		rst = 1'b0;
		for (int i = 0; i < 15; i++) begin
			r = rows[i];
			req(r[12], r[11:10], r[9:4]);
			check(rd_data, (r[3:2] == 2'h0 && r[12]) ? 64'h28000EA1 : 64'h0);
			check(64'(flags), 64'({2'h3, r[3:0], r[2] ? 6'h18 : 6'h0}));
		end
		rd_crm = 4'h9;
		@(negedge mclk);
		check(64'(flags), 64'h800);
		check(rd_data, 64'h0);
		rd_req = 1'b0;
		@(negedge mclk);
		check(64'(flags), 64'h0);
		rst = 1'b1;
		req(1'b1, 2'h3, 6'h0);
		check(64'(flags), 64'h0);
		check(rd_data, 64'h0);
		rst = 1'b0;
		@(negedge mclk);
		check(rd_data, 64'h0000_0000_2800_0EA1);
		rd_req = 1'b0;
		@(negedge mclk);
		conclude();
	end
	initial begin
		#(300 * 100);
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
